// ---- hdl/pcd_pkg.sv ----
/*
  pcd_pkg: constants and types for the standby power condition descriptor block.
  assumes a single pclk domain and an apb master on the register side.
*/
package pcd_pkg;
  localparam logic [11:0] PCD_OFF_RSVD_LO   = 12'h000;
  localparam logic [11:0] PCD_OFF_DESC_Y    = 12'h180;
  localparam logic [11:0] PCD_OFF_DESC_Z    = 12'h1C0;
  localparam logic [11:0] PCD_OFF_CTRL      = 12'h200;
  localparam logic [11:0] PCD_OFF_STATUS    = 12'h204;
  localparam logic [11:0] PCD_OFF_CFG_Y     = 12'h208;
  localparam logic [11:0] PCD_OFF_CFG_Z     = 12'h20C;
  localparam logic [11:0] PCD_OFF_TMR_Y     = 12'h210;
  localparam logic [11:0] PCD_OFF_TMR_Z     = 12'h214;
  localparam logic [11:0] PCD_PAGE_END      = 12'h200;
  localparam logic [5:0]  PCD_DESC_RSVD_B   = 6'h00;
  localparam logic [5:0]  PCD_DESC_FLAG_B   = 6'h01;
  localparam logic [5:0]  PCD_DESC_CUR_B    = 6'h0C;
  localparam int          PCD_BIT_SUP       = 7;
  localparam int          PCD_BIT_SAVE      = 6;
  localparam int          PCD_BIT_CHG       = 5;
  localparam int          PCD_BIT_DEF       = 4;
  localparam int          PCD_BIT_SAVED     = 3;
  localparam int          PCD_BIT_CUR       = 2;
  localparam int          PCD_UNIT_MS       = 100;
  localparam int          PCD_CLK_MHZ       = 100;
  localparam int          PCD_UNIT_CYC      = PCD_UNIT_MS * 1000 * PCD_CLK_MHZ;
  localparam logic [31:0] PCD_RST_WORD      = 32'h0000_0000;
  localparam logic [7:0]  PCD_RST_BYTE      = 8'h00;

  typedef struct packed {
    logic       sup;
    logic       savable;
    logic       changeable;
    logic       def_en;
    logic       saved_en;
    logic       cur_en;
  } pcd_cfg_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        epc_en;
    pcd_cfg_t    cfg_y;
    pcd_cfg_t    cfg_z;
    logic [31:0] tmr_y;
    logic [31:0] tmr_z;
    logic [31:0] cnt_y;
    logic [31:0] cnt_z;
    logic [31:0] pre_y;
    logic [31:0] pre_z;
    logic        ent_y;
    logic        ent_z;
  } pcd_state_t;
endpackage

// ---- hdl/pcd_flags.sv ----
/*
  pcd_flags: apb register bank serving the standby power conditions log page
  (byte 0-511 read-only window, word addressed) plus control and timer logic.
  assumes pclk at 100 MHz, apb master per the amba spec, cmd_done pulse
  from the command engine on the same clock.
*/
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module pcd_flags import pcd_pkg::*; #(
  parameter int UNIT_CYC = PCD_UNIT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_done,
  output logic             enter_y,
  output logic             enter_z
);
  pcd_state_t s;
  pcd_state_t next_s;
  logic       wr;
  logic       rd;
  logic [7:0] flag_y;
  logic [7:0] flag_z;
  logic [31:0] cur_y;
  logic [31:0] cur_z;
  logic       run_y;
  logic       run_z;
  logic       mapped;

  assign wr = psel && penable && pwrite && clk_en;
  assign rd = psel && !penable && !pwrite && clk_en;
  assign pready = 1'b1;
  assign mapped = (paddr < PCD_OFF_TMR_Z + 12'h004);
  assign pslverr = psel && penable && !mapped;
  assign prdata = s.prdata;
  assign enter_y = s.ent_y;
  assign enter_z = s.ent_z;

  function automatic logic [7:0] flag_of(input pcd_cfg_t c, input logic epc);
    logic [7:0] f;
    f = PCD_RST_BYTE;
    f[PCD_BIT_SUP]   = c.sup;
    f[PCD_BIT_SAVE]  = c.sup & c.savable;
    f[PCD_BIT_CHG]   = c.sup & c.changeable;
    f[PCD_BIT_DEF]   = c.sup & c.def_en;
    f[PCD_BIT_SAVED] = c.sup & c.saved_en;
    f[PCD_BIT_CUR]   = c.sup & c.cur_en & epc;
    return f;
  endfunction

  assign flag_y = flag_of(s.cfg_y, s.epc_en);
  assign flag_z = flag_of(s.cfg_z, s.epc_en);
  assign cur_y = flag_y[PCD_BIT_CUR] ? s.tmr_y : PCD_RST_WORD;
  assign cur_z = flag_z[PCD_BIT_CUR] ? s.tmr_z : PCD_RST_WORD;
  assign run_y = s.epc_en && flag_y[PCD_BIT_CUR] && (cur_y != 32'h0000_0000);
  assign run_z = s.epc_en && flag_z[PCD_BIT_CUR] && (cur_z != 32'h0000_0000);

  function automatic logic [31:0] desc_word(input logic [5:0] b, input logic [7:0] f,
                                            input logic [31:0] cur);
    logic [31:0] w;
    w = PCD_RST_WORD;
    if ({b[5:2], 2'b00} == PCD_DESC_RSVD_B) begin
      w[15:8] = f;
    end else if ({b[5:2], 2'b00} == PCD_DESC_CUR_B) begin
      w = cur;
    end
    return w;
  endfunction

  always_comb begin
    next_s = s;
    next_s.ent_y = 1'b0;
    next_s.ent_z = 1'b0;
    if (rd) begin
      next_s.prdata = PCD_RST_WORD;
      if (paddr < PCD_OFF_DESC_Y) begin
        next_s.prdata = PCD_RST_WORD;
      end else if (paddr < PCD_OFF_DESC_Z) begin
        next_s.prdata = desc_word(paddr[5:0], flag_y, cur_y);
      end else if (paddr < PCD_PAGE_END) begin
        next_s.prdata = desc_word(paddr[5:0], flag_z, cur_z);
      end else begin
        unique case (paddr)
          PCD_OFF_CTRL:   next_s.prdata = {31'h0, s.epc_en};
          PCD_OFF_STATUS: next_s.prdata = {28'h0, s.ent_z, s.ent_y, run_z, run_y};
          PCD_OFF_CFG_Y:  next_s.prdata = {26'h0, s.cfg_y};
          PCD_OFF_CFG_Z:  next_s.prdata = {26'h0, s.cfg_z};
          PCD_OFF_TMR_Y:  next_s.prdata = s.tmr_y;
          PCD_OFF_TMR_Z:  next_s.prdata = s.tmr_z;
          default:        next_s.prdata = PCD_RST_WORD;
        endcase
      end
    end
    if (wr && pstrb[0]) begin
      unique case (paddr)
        PCD_OFF_CTRL:  next_s.epc_en = pwdata[0];
        PCD_OFF_CFG_Y: next_s.cfg_y = pwdata[5:0];
        PCD_OFF_CFG_Z: next_s.cfg_z = pwdata[5:0];
        default: ;
      endcase
    end
    if (wr && pstrb == 4'hF) begin
      if (paddr == PCD_OFF_TMR_Y) next_s.tmr_y = pwdata;
      if (paddr == PCD_OFF_TMR_Z) next_s.tmr_z = pwdata;
    end
    // idle timers count 100 ms units after command completion
    if (!run_y || cmd_done) begin
      next_s.cnt_y = PCD_RST_WORD;
      next_s.pre_y = PCD_RST_WORD;
    end else if (s.cnt_y < cur_y) begin
      if (s.pre_y == 32'(UNIT_CYC - 1)) begin
        next_s.pre_y = PCD_RST_WORD;
        next_s.cnt_y = s.cnt_y + 32'h1;
        next_s.ent_y = (s.cnt_y + 32'h1 == cur_y);
      end else begin
        next_s.pre_y = s.pre_y + 32'h1;
      end
    end
    if (!run_z || cmd_done) begin
      next_s.cnt_z = PCD_RST_WORD;
      next_s.pre_z = PCD_RST_WORD;
    end else if (s.cnt_z < cur_z) begin
      if (s.pre_z == 32'(UNIT_CYC - 1)) begin
        next_s.pre_z = PCD_RST_WORD;
        next_s.cnt_z = s.cnt_z + 32'h1;
        next_s.ent_z = (s.cnt_z + 32'h1 == cur_z);
      end else begin
        next_s.pre_z = s.pre_z + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  property p_cur_zero_when_off;
    @(posedge pclk) disable iff (!presetn)
      !s.epc_en |-> (flag_y[PCD_BIT_CUR] == 1'b0 && cur_y == 32'h0);
  endproperty
  a_cur_zero_when_off: assert property (p_cur_zero_when_off) else $error("cur flag set with epc off");

  property p_rsvd_low;
    @(posedge pclk) disable iff (!presetn)
      (flag_y[1:0] == 2'b00) && (flag_z[1:0] == 2'b00);
  endproperty
  a_rsvd_low: assert property (p_rsvd_low) else $error("reserved flag bits set");

  property p_sup_bit;
    @(posedge pclk) disable iff (!presetn)
      (flag_z[PCD_BIT_SUP] == s.cfg_z.sup) && (s.cfg_z.sup || flag_z == 8'h00);
  endproperty
  a_sup_bit: assert property (p_sup_bit) else $error("supported bit mismatch");

  property p_page_rsvd;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr < PCD_OFF_DESC_Y) |=> (prdata == 32'h0);
  endproperty
  a_page_rsvd: assert property (p_page_rsvd) else $error("reserved page area nonzero");

  property p_flag_y_read;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == PCD_OFF_DESC_Y) |=> (prdata[15:8] == $past(flag_y) && prdata[7:0] == 8'h0);
  endproperty
  a_flag_y_read: assert property (p_flag_y_read) else $error("standby_y flag read wrong");

  property p_flag_z_read;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == PCD_OFF_DESC_Z) |=> (prdata[15:8] == $past(flag_z));
  endproperty
  a_flag_z_read: assert property (p_flag_z_read) else $error("standby_z flag read wrong");

  property p_no_run;
    @(posedge pclk) disable iff (!presetn)
      (s.epc_en && !s.cfg_y.cur_en) |=> (s.cnt_y == 32'h0 && !s.ent_y);
  endproperty
  a_no_run: assert property (p_no_run) else $error("timer ran while disabled");

  property p_run_cond;
    @(posedge pclk) disable iff (!presetn)
      run_z |-> (s.epc_en && s.cfg_z.sup && s.cfg_z.cur_en && s.tmr_z != 32'h0);
  endproperty
  a_run_cond: assert property (p_run_cond) else $error("timer run without conditions");

  property p_save_bit;
    @(posedge pclk) disable iff (!presetn)
      flag_y[PCD_BIT_SAVE] == (s.cfg_y.sup && s.cfg_y.savable)
      && flag_y[PCD_BIT_CHG] == (s.cfg_y.sup && s.cfg_y.changeable);
  endproperty
  a_save_bit: assert property (p_save_bit) else $error("savable or changeable wrong");

  property p_def_bits;
    @(posedge pclk) disable iff (!presetn)
      $rose(s.epc_en) |-> (flag_y[4:3] == $past(flag_y[4:3]));
  endproperty
  a_def_bits: assert property (p_def_bits) else $error("timer enable bits follow epc");

  property p_cur_zero_z;
    @(posedge pclk) disable iff (!presetn)
      !s.epc_en |-> (flag_z[PCD_BIT_CUR] == 1'b0 && cur_z == 32'h0);
  endproperty
  a_cur_zero_z: assert property (p_cur_zero_z) else $error("z cur flag set with epc off");

  property p_cur_clr_y;
    @(posedge pclk) disable iff (!presetn)
      (!s.cfg_y.sup || !s.cfg_y.cur_en) |-> (cur_y == 32'h0);
  endproperty
  a_cur_clr_y: assert property (p_cur_clr_y) else $error("y current timer not cleared");

  property p_cur_clr_z;
    @(posedge pclk) disable iff (!presetn)
      (!s.cfg_z.sup || !s.cfg_z.cur_en) |-> (cur_z == 32'h0);
  endproperty
  a_cur_clr_z: assert property (p_cur_clr_z) else $error("z current timer not cleared");

  property p_sup_y;
    @(posedge pclk) disable iff (!presetn)
      flag_y[PCD_BIT_SUP] == s.cfg_y.sup;
  endproperty
  a_sup_y: assert property (p_sup_y) else $error("y supported bit mismatch");

  property p_sup_clr_y;
    @(posedge pclk) disable iff (!presetn)
      !s.cfg_y.sup |-> (flag_y == 8'h00);
  endproperty
  a_sup_clr_y: assert property (p_sup_clr_y) else $error("y flags set while unsupported");

  property p_save_z;
    @(posedge pclk) disable iff (!presetn)
      flag_z[PCD_BIT_SAVE] == (s.cfg_z.sup && s.cfg_z.savable)
      && flag_z[PCD_BIT_CHG] == (s.cfg_z.sup && s.cfg_z.changeable);
  endproperty
  a_save_z: assert property (p_save_z) else $error("z savable or changeable wrong");

  property p_def_y;
    @(posedge pclk) disable iff (!presetn)
      flag_y[PCD_BIT_DEF] == (s.cfg_y.sup && s.cfg_y.def_en)
      && flag_y[PCD_BIT_SAVED] == (s.cfg_y.sup && s.cfg_y.saved_en);
  endproperty
  a_def_y: assert property (p_def_y) else $error("y timer enable bits wrong");

  property p_def_z;
    @(posedge pclk) disable iff (!presetn)
      flag_z[PCD_BIT_DEF] == (s.cfg_z.sup && s.cfg_z.def_en)
      && flag_z[PCD_BIT_SAVED] == (s.cfg_z.sup && s.cfg_z.saved_en);
  endproperty
  a_def_z: assert property (p_def_z) else $error("z timer enable bits wrong");

  property p_no_run_z;
    @(posedge pclk) disable iff (!presetn)
      (s.epc_en && !s.cfg_z.cur_en) |=> (s.cnt_z == 32'h0 && !s.ent_z);
  endproperty
  a_no_run_z: assert property (p_no_run_z) else $error("z timer ran while disabled");

  property p_run_y;
    @(posedge pclk) disable iff (!presetn)
      run_y |-> (s.epc_en && s.cfg_y.sup && s.cfg_y.cur_en && s.tmr_y != 32'h0);
  endproperty
  a_run_y: assert property (p_run_y) else $error("y timer run without conditions");

  property p_run_ok_y;
    @(posedge pclk) disable iff (!presetn)
      (s.epc_en && s.cfg_y.sup && s.cfg_y.cur_en && s.tmr_y != 32'h0) |-> run_y;
  endproperty
  a_run_ok_y: assert property (p_run_ok_y) else $error("y timer stopped when enabled");

  property p_run_ok_z;
    @(posedge pclk) disable iff (!presetn)
      (s.epc_en && s.cfg_z.sup && s.cfg_z.cur_en && s.tmr_z != 32'h0) |-> run_z;
  endproperty
  a_run_ok_z: assert property (p_run_ok_z) else $error("z timer stopped when enabled");

  property p_ent_pulse_y;
    @(posedge pclk) disable iff (!presetn)
      (s.ent_y && clk_en) |=> !s.ent_y;
  endproperty
  a_ent_pulse_y: assert property (p_ent_pulse_y) else $error("y entry not a single pulse");

  property p_ent_pulse_z;
    @(posedge pclk) disable iff (!presetn)
      (s.ent_z && clk_en) |=> !s.ent_z;
  endproperty
  a_ent_pulse_z: assert property (p_ent_pulse_z) else $error("z entry not a single pulse");

  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(s);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state changed while frozen");

  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && paddr >= PCD_OFF_TMR_Z + 12'h004) |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");

  property p_log_ro;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr < PCD_PAGE_END) |=> ($stable(s.cfg_y) && $stable(s.cfg_z)
      && $stable(s.epc_en) && $stable(s.tmr_y) && $stable(s.tmr_z));
  endproperty
  a_log_ro: assert property (p_log_ro) else $error("log page write changed state");

  property p_rsvd_byte_z;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == PCD_OFF_DESC_Z) |=> (prdata[7:0] == 8'h0 && prdata[31:16] == 16'h0);
  endproperty
  a_rsvd_byte_z: assert property (p_rsvd_byte_z) else $error("z reserved bytes nonzero");

  property p_cur_read_y;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == PCD_OFF_DESC_Y + 12'h00C) |=> (prdata == $past(cur_y));
  endproperty
  a_cur_read_y: assert property (p_cur_read_y) else $error("y current timer read wrong");

  property p_cur_read_z;
    @(posedge pclk) disable iff (!presetn)
      (rd && paddr == PCD_OFF_DESC_Z + 12'h00C) |=> (prdata == $past(cur_z));
  endproperty
  a_cur_read_z: assert property (p_cur_read_z) else $error("z current timer read wrong");

  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && pstrb[0] && paddr == PCD_OFF_CTRL) |=> (s.epc_en == $past(pwdata[0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("epc enable write lost");

  c_enter_y: cover property (@(posedge pclk) disable iff (!presetn) s.ent_y);
  c_enter_z: cover property (@(posedge pclk) disable iff (!presetn) s.ent_z);
  c_slverr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_epc_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(s.epc_en));
  c_flag_read: cover property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == PCD_OFF_DESC_Z);
endmodule
`default_nettype wire

// ---- tb/pcd_host.sv ----
/*
  pcd_host: apb master standing in for the host that reads the log page.
  assumes tasks are entered right after a rising pclk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module pcd_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
  end
  // setup, then access until pready; one idle edge after release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ---- tb/pcd_flags_tb.sv ----
/*
  pcd_flags_tb: random flag and timer configurations checked through the log page.
  assumes pcd_host as apb master and a small UNIT_CYC.
*/
`timescale 1ns/1ns
`default_nettype none
module pcd_flags_tb import pcd_pkg::*;;
  typedef struct packed {logic [31:0] val; logic [31:0] mask; logic err;} pcd_exp_t;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic        cmd_done, enter_y, enter_z, epc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ty, tz;
  logic [3:0]  pstrb;
  logic [5:0]  cy, cz;
  pcd_exp_t    exp_q[$];
  pcd_exp_t    e;
  int          bad_count, total_checks, hits_y, hits_z;
  integer      seed = 32'ha7fa8f73;
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  pcd_flags #(.UNIT_CYC(4)) pcd_flags_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_done(cmd_done), .enter_y(enter_y), .enter_z(enter_z));
  pcd_host pcd_host_i (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  function automatic logic [7:0] flg(logic [5:0] c, logic en);
    return c[5] ? {1'b1, c[4:1], c[0] & en, 2'b00} : 8'h00;
  endfunction
  task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back('{v, m, a >= 12'h218});
    pcd_host_i.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    exp_q.push_back('{32'h0, 32'h0, a >= 12'h218});
    pcd_host_i.xfer(1'b1, a, d);
  endtask
  task automatic check(input string n, input bit ok);
    total_checks++;
    if (!ok) begin
      bad_count++;
      $display("wrong value %s expected 1 seen 0", n);
    end
  endtask
  task automatic cfg_all;
    wr(12'h200, {31'h0, epc});
    wr(12'h208, {26'h0, cy});
    wr(12'h20C, {26'h0, cz});
    wr(12'h210, ty);
    wr(12'h214, tz);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      total_checks++;
      if ((prdata & e.mask) !== (e.val & e.mask) || pslverr !== e.err) begin
        bad_count++;
        $display("wrong value at %h expected %h/%b seen %h/%b", paddr, e.val, e.err,
                 prdata & e.mask, pslverr);
      end
    end
    if (enter_y === 1'b1) hits_y++;
    if (enter_z === 1'b1) hits_z++;
  end
  initial begin
    #100000;
    bad_count++;
    $display("watchdog expired");
    conclude();
  end
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    cmd_done = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h200, 32'h0, '1);
    rd(12'h208, 32'h0, '1);
    for (int i = 0; i < 8; i++) begin
      wr(12'(({$random(seed)} % 96) * 4), $random(seed));
      rd(paddr, 32'h0, '1);
    end
    $display("test reserved done");
    for (int i = 0; i < 16; i++) begin
      cy = 6'($random(seed));
      cz = 6'($random(seed));
      epc = i[0];
      ty = {$random(seed)} % 4;
      tz = {$random(seed)} % 4;
      cfg_all();
      wr(12'h1C4, 32'hFFFF_FFFF);
      rd(12'h180, {16'h0, flg(cy, epc), 8'h00}, '1);
      rd(12'h1C0, {16'h0, flg(cz, epc), 8'h00}, '1);
      rd(12'h18C, (epc & cy[5] & cy[0]) ? ty : 32'h0, '1);
      rd(12'h1CC, (epc & cz[5] & cz[0]) ? tz : 32'h0, '1);
      rd(12'h204, {30'h0, epc & cz[0] & (tz != 0), epc & cy[0] & (ty != 0)},
         {30'h0, cz[5], cy[5]});
    end
    wr(12'h218, 32'h0000_0001);
    rd(12'h21C, 32'h0, '1);
    $display("test flags done");
    for (int k = 0; k < 3; k++) begin
      cy = 6'h21;
      cz = 6'h20;
      epc = (k == 0);
      ty = (k == 2) ? 32'h0 : 32'h2;
      tz = 32'h2;
      cfg_all();
      cmd_done <= 1'b1;
      @(posedge pclk);
      cmd_done <= 1'b0;
      hits_y = 0;
      hits_z = 0;
      repeat (3) @(posedge pclk);
      check("early entry", hits_y == 0);
      repeat (30) @(posedge pclk);
      check("entry y", (hits_y > 0) == (k == 0));
      check("entry z", hits_z == 0);
    end
    $display("test timer done");
    clk_en <= 1'b0;
    wr(12'h200, 32'h0000_0001);
    clk_en <= 1'b1;
    rd(12'h200, 32'h0, '1);
    $display("test freeze done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h200, 32'h0, '1);
    rd(12'h1C0, 32'h0, '1);
    repeat (2) @(posedge pclk);
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
